// File: logic/rca_top.sv
// Real-time clock: source select, prescaler, 32-bit counter, alarm, backup words.
// Assumes all control inputs and slow source levels are synchronous to clk.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// (RULE1) Time base is selected from low-speed crystal, low-power oscillator or divided HSE.
// (RULE2) High-speed external clock is divided by a fixed 128 before the prescaler.
// (RULE3) Programmable 20-bit prescaler; reset value gives one tick per second.
// (RULE4) 32-bit counter that software can load for long intervals.
// (RULE5) Counters run continuously without any software restart.
// (RULE6) Compare value held; alarm raised when counter matches it.
// (RULE7) Two separate interrupt sources: alarm and periodic.
// (RULE8) 512 Hz derived clock driven out for calibration.
// (RULE9) Ten 16-bit backup registers, twenty bytes of retained storage.
// (RULE10) Counter increments on prescaler terminal count; periodic flag set same tick.
// (RULE11) Alarm flag sets when counter becomes equal to compare; held until cleared. Code sets it only on a tick, not on cnt_wr or cmp_wr.
module rca_top #(
    parameter int PRESC_W = rca_pkg::RCA_PRESC_W,
    parameter int CNT_W = rca_pkg::RCA_CNT_W,
    parameter int BKP_N = rca_pkg::RCA_BKP_N
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] src_sel,
    input wire logic lse_clk,
    input wire logic lsi_clk,
    input wire logic hse_clk,
    input wire logic presc_wr,
    input wire logic [PRESC_W-1:0] presc_data,
    input wire logic cnt_wr,
    input wire logic [CNT_W-1:0] cnt_data,
    input wire logic cmp_wr,
    input wire logic [CNT_W-1:0] cmp_data,
    input wire logic alarm_clr,
    input wire logic tick_clr,
    input wire logic cal_en,
    input wire logic bkp_wr,
    input wire logic [rca_pkg::RCA_BKP_AW-1:0] bkp_wr_addr,
    input wire logic [rca_pkg::RCA_BKP_W-1:0] bkp_wr_data,
    input wire logic [rca_pkg::RCA_BKP_AW-1:0] bkp_rd_addr,
    output logic [rca_pkg::RCA_BKP_W-1:0] bkp_rd_data,
    output logic [CNT_W-1:0] count,
    output logic [CNT_W-1:0] compare,
    output logic [PRESC_W-1:0] presc_left,
    output logic alarm_irq,
    output logic tick_irq,
    output logic cal_out
);
    generate
        if (PRESC_W < 16 || PRESC_W > 32 || CNT_W < 1 || CNT_W > 64) begin : g_bad
            $error("rca_top: unsupported PRESC_W or CNT_W");
        end
        if (BKP_N < 1 || BKP_N > (1 << rca_pkg::RCA_BKP_AW)) begin : g_bad_bkp
            $error("rca_top: BKP_N does not fit the backup address");
        end
    endgenerate

    logic lse_q;
    logic lsi_q;
    logic hse_q;
    logic lse_edge;
    logic lsi_edge;
    logic hse_edge;
    logic [rca_pkg::RCA_HSE_W-1:0] hse_div;
    logic hse_pulse;
    logic src_edge;
    logic [PRESC_W-1:0] presc_reload;
    logic tick;
    logic [CNT_W-1:0] next_count;
    logic [rca_pkg::RCA_CAL_W-1:0] cal_div;

    ////////////////////////////////////////////////////////////////////////////
    // Source edge detection and selection

    // Not reset: following the pins through reset avoids a false edge at release
    // Each source must stay high and low for a clock at least, or edges are lost
    always_ff @(posedge clk) begin
        lse_q <= lse_clk;
        lsi_q <= lsi_clk;
        hse_q <= hse_clk;
    end

    assign lse_edge = lse_clk && !lse_q;
    assign lsi_edge = lsi_clk && !lsi_q;
    assign hse_edge = hse_clk && !hse_q;

    // Divide HSE rising edges down by 128
    always_ff @(posedge clk) begin
        if (srst) begin
            hse_div <= '0;
            hse_pulse <= 1'b0;
        end else begin
            hse_pulse <= 1'b0;
            if (hse_edge) begin
                hse_div <= hse_div + 1'b1; // (RULE2)
                hse_pulse <= (hse_div == rca_pkg::RCA_HSE_W'(rca_pkg::RCA_HSE_DIV - 1));
            end
        end
    end

    // Unused select code falls back to the crystal
    always_comb begin
        unique case (src_sel)
            2'(rca_pkg::RCA_SRC_LSE): src_edge = lse_edge; // (RULE1)
            2'(rca_pkg::RCA_SRC_LSI): src_edge = lsi_edge; // (RULE1)
            2'(rca_pkg::RCA_SRC_HSE): src_edge = hse_pulse; // (RULE1)
            default: src_edge = lse_edge; // (RULE1)
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    always_ff @(posedge clk) begin
        if (srst) begin
            presc_reload <= PRESC_W'(rca_pkg::RCA_PRESC_RST); // (RULE3)
        end else if (presc_wr) begin
            presc_reload <= presc_data; // (RULE3)
        end
    end

    // Down-counter; a new reload value takes effect at once
    // Terminal count is zero, so a reload value R divides by R + 1
    always_ff @(posedge clk) begin
        if (srst) begin
            presc_left <= PRESC_W'(rca_pkg::RCA_PRESC_RST);
        end else if (presc_wr) begin
            presc_left <= presc_data;
        end else if (src_edge) begin
            if (presc_left == '0) begin
                presc_left <= presc_reload; // (RULE5)
            end else begin
                presc_left <= presc_left - 1'b1; // (RULE3)
            end
        end
    end

    assign tick = src_edge && !presc_wr && (presc_left == '0); // (RULE10)

    ////////////////////////////////////////////////////////////////////////////
    // Counter, compare and flags

    // Software load wins over a coincident tick
    always_comb begin
        if (cnt_wr) begin
            next_count = cnt_data; // (RULE4)
        end else if (tick) begin
            next_count = count + 1'b1; // (RULE10)
        end else begin
            next_count = count;
        end
    end

    // Wraps from all ones to zero; no overflow flag is kept
    always_ff @(posedge clk) begin
        if (srst) begin
            count <= CNT_W'(rca_pkg::RCA_CNT_RST);
        end else begin
            count <= next_count; // (RULE5)
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            compare <= CNT_W'(rca_pkg::RCA_CMP_RST);
        end else if (cmp_wr) begin
            compare <= cmp_data; // (RULE6)
        end
    end

    // Set beats clear so no event is lost
    always_ff @(posedge clk) begin
        if (srst) begin
            alarm_irq <= 1'b0;
        end else if (tick && !cnt_wr && (next_count == compare)) begin
            alarm_irq <= 1'b1; // (RULE11)
        end else if (alarm_clr) begin
            alarm_irq <= 1'b0; // (RULE7)
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tick_irq <= 1'b0;
        end else if (tick) begin
            tick_irq <= 1'b1; // (RULE10)
        end else if (tick_clr) begin
            tick_irq <= 1'b0; // (RULE7)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration output: exact 512 Hz only from a 32.768 kHz source
    // Divider restarts whenever the output is switched off

    always_ff @(posedge clk) begin
        if (srst || !cal_en) begin
            cal_div <= '0;
            cal_out <= 1'b0;
        end else if (src_edge) begin
            cal_div <= cal_div + 1'b1;
            if (cal_div == rca_pkg::RCA_CAL_W'(rca_pkg::RCA_CAL_HALF - 1)) begin
                cal_out <= !cal_out; // (RULE8)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Backup words

    rca_backup_mem #(
        .WIDTH(rca_pkg::RCA_BKP_W),
        .DEPTH(BKP_N),
        .AW(rca_pkg::RCA_BKP_AW)
    ) u_bkp (
        .clk(clk),
        .srst(srst),
        .wr_en(bkp_wr),
        .wr_addr(bkp_wr_addr),
        .wr_data(bkp_wr_data),
        .rd_addr(bkp_rd_addr),
        .rd_data(bkp_rd_data)
    ); // (RULE9)
endmodule
`default_nettype wire

// File: logic/rca_pkg.sv
// Constants shared by the real-time clock counter block.
// Assumes one 40 MHz system clock; slow sources arrive as synchronous levels.
`default_nettype none
package rca_pkg;
    // Time-base source choices
    typedef enum logic [1:0] {
        RCA_SRC_LSE,
        RCA_SRC_LSI,
        RCA_SRC_HSE
    } rca_src_e;

    localparam int RCA_PRESC_W = 20;
    localparam int RCA_CNT_W = 32;
    localparam int RCA_BKP_W = 16;
    localparam int RCA_BKP_N = 10;
    localparam int RCA_BKP_AW = 4;

    localparam int RCA_CLK_HZ = 40000000;
    localparam int RCA_LSE_HZ = 32768;
    localparam int RCA_CAL_HZ = 512;
    localparam int RCA_HSE_DIV = 128;
    // Half period of the calibration output, in source edges
    localparam int RCA_CAL_HALF = RCA_LSE_HZ / (2 * RCA_CAL_HZ);
    localparam int RCA_CAL_W = $clog2(RCA_CAL_HALF);
    localparam int RCA_HSE_W = $clog2(RCA_HSE_DIV);

    // One tick per second from the low-speed crystal
    localparam logic [RCA_PRESC_W-1:0] RCA_PRESC_RST = 20'(RCA_LSE_HZ - 1);
    localparam logic [RCA_CNT_W-1:0] RCA_CNT_RST = 32'h0000_0000;
    localparam logic [RCA_CNT_W-1:0] RCA_CMP_RST = 32'hFFFF_FFFF;
endpackage
`default_nettype wire

// File: logic/rca_backup_mem.sv
// Backup storage words with registered read data.
// Assumes the array itself is kept across main-power loss; only the read port resets.
`default_nettype none
module rca_backup_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 10,
    parameter int AW = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    generate
        if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad
            $error("rca_backup_mem: DEPTH does not fit AW");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];

    // Storage deliberately has no reset: it must survive a system reset
    always_ff @(posedge clk) begin
        if (wr_en && (32'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data; // (RULE9)
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (32'(rd_addr) < DEPTH) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= '0;
        end
    end
endmodule
`default_nettype wire

// File: dv/rca_monitor.sv
// Port-level checker for the real-time clock counter block.
// Assumes one clock domain, srst synchronous active high.
`default_nettype none
module rca_monitor #(
    parameter int PRESC_W = 20,
    parameter int CNT_W = 32,
    parameter int BKP_N = 10
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic presc_wr,
    input wire logic [PRESC_W-1:0] presc_data,
    input wire logic cnt_wr,
    input wire logic [CNT_W-1:0] cnt_data,
    input wire logic cmp_wr,
    input wire logic [CNT_W-1:0] cmp_data,
    input wire logic alarm_clr,
    input wire logic tick_clr,
    input wire logic cal_en,
    input wire logic [3:0] bkp_rd_addr,
    input wire logic [15:0] bkp_rd_data,
    input wire logic [CNT_W-1:0] count,
    input wire logic [CNT_W-1:0] compare,
    input wire logic [PRESC_W-1:0] presc_left,
    input wire logic alarm_irq,
    input wire logic tick_irq,
    input wire logic cal_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    a_count_step: assert property (!cnt_wr |=>
        count == $past(count) || count == $past(count) + 1'b1) else $error("count jump");
    a_tick_flag: assert property (!cnt_wr ##1 count != $past(count) |-> tick_irq)
        else $error("tick flag missing");
    a_cnt_load: assert property (cnt_wr |=> count == $past(cnt_data))
        else $error("count load lost");
    a_cmp_load: assert property (cmp_wr |=> compare == $past(cmp_data))
        else $error("compare load lost");
    a_cmp_hold: assert property (!cmp_wr |=> $stable(compare))
        else $error("compare drift");
    a_alarm_cause: assert property ($rose(alarm_irq) |-> count == compare && tick_irq)
        else $error("alarm without match");
    a_alarm_hold: assert property (alarm_irq && !alarm_clr |=> alarm_irq)
        else $error("alarm dropped");
    a_tick_hold: assert property (tick_irq && !tick_clr |=> tick_irq)
        else $error("tick dropped");
    a_presc_load: assert property (presc_wr |=> presc_left == $past(presc_data))
        else $error("prescaler load lost");
    a_cal_idle: assert property (!cal_en |=> !cal_out)
        else $error("cal out while off");
    a_bkp_range: assert property (bkp_rd_addr >= BKP_N |=> bkp_rd_data == 16'h0000)
        else $error("backup out of range");
    // Main scenarios reached
    c_alarm: cover property ($rose(alarm_irq));
    c_tick: cover property ($rose(tick_irq));
    c_cal: cover property ($rose(cal_out));
endmodule
////////////////////////////////////////////////////////////////////////////////
bind rca_top rca_monitor #(.PRESC_W(PRESC_W), .CNT_W(CNT_W), .BKP_N(BKP_N)) u_rca_monitor (
    .clk, .srst, .presc_wr, .presc_data, .cnt_wr, .cnt_data, .cmp_wr, .cmp_data, .alarm_clr,
    .tick_clr, .cal_en, .bkp_rd_addr, .bkp_rd_data, .count, .compare, .presc_left,
    .alarm_irq, .tick_irq, .cal_out);
`default_nettype wire

// File: dv/tb_top.sv
// Directed testbench for the real-time clock counter block.
// Assumes the checker is bound in; source levels are toggled from the bench.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, srst, presc_wr, cnt_wr, cmp_wr, alarm_clr, tick_clr, cal_en, bkp_wr;
    logic alarm_irq, tick_irq, cal_out;
    logic [1:0] src_sel;
    logic [2:0] lv;
    logic [19:0] presc_data, presc_left;
    logic [31:0] cnt_data, cmp_data, count, compare;
    logic [3:0] bkp_wr_addr, bkp_rd_addr;
    logic [15:0] bkp_wr_data, bkp_rd_data;
    int n_errors = 0;
    int cmp_count = 0;
    rca_top u_rca_top (.clk, .srst, .src_sel, .lse_clk(lv[0]), .lsi_clk(lv[1]),
        .hse_clk(lv[2]), .presc_wr, .presc_data, .cnt_wr, .cnt_data, .cmp_wr, .cmp_data,
        .alarm_clr, .tick_clr, .cal_en, .bkp_wr, .bkp_wr_addr, .bkp_wr_data, .bkp_rd_addr,
        .bkp_rd_data, .count, .compare, .presc_left, .alarm_irq, .tick_irq, .cal_out);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Two cycles per edge, so every rise is seen as a separate edge
    task automatic edges(input int n, input int k);
        repeat (n) begin
            @(negedge clk) lv[k] = 1'b1;
            @(negedge clk) lv[k] = 1'b0;
        end
    endtask
    // k: 0 prescaler, 1 count, 2 compare, 3 alarm clear, 4 tick clear
    task automatic wr(input int k, input logic [31:0] d);
        @(negedge clk);
        presc_data = d[19:0];
        cnt_data = d;
        cmp_data = d;
        {presc_wr, cnt_wr, cmp_wr, alarm_clr, tick_clr} = 5'h10 >> k;
        @(negedge clk) {presc_wr, cnt_wr, cmp_wr, alarm_clr, tick_clr} = 5'h00;
    endtask
    task automatic finish_test();
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(count, 32'h0);
        chk(compare, 32'hFFFF_FFFF);
        chk(presc_left, 32'h7FFF);
        chk({alarm_irq, tick_irq}, 32'h0);
    endtask
    task automatic t_tick();
        wr(0, 32'h2);
        edges(2, 0);
        chk(count, 32'h0);
        edges(1, 0);
        chk({count[3:0], tick_irq}, 32'h3);
        wr(4, 32'h0);
        chk(tick_irq, 32'h0);
        edges(3, 0);
        chk(count, 32'h2);
    endtask
    task automatic t_alarm();
        wr(2, 32'h4);
        chk(compare, 32'h4);
        edges(3, 0);
        chk({count[3:0], alarm_irq}, 32'h6);
        edges(3, 0);
        chk(alarm_irq, 32'h1);
        edges(3, 0);
        chk(alarm_irq, 32'h1);
        wr(3, 32'h0);
        chk({alarm_irq, tick_irq}, 32'h1);
    endtask
    // Wrap at the top of the 32-bit range
    task automatic t_load();
        wr(1, 32'hFFFF_FFFE);
        edges(3, 0);
        chk(count, 32'hFFFF_FFFF);
        edges(3, 0);
        chk(count, 32'h0);
    endtask
    task automatic t_src();
        src_sel = 2'h1;
        edges(3, 0);
        chk(count, 32'h0);
        edges(3, 1);
        chk(count, 32'h1);
        src_sel = 2'h2;
        wr(0, 32'h0);
        edges(127, 2);
        chk(count, 32'h1);
        edges(1, 2);
        repeat (2) @(negedge clk);
        chk(count, 32'h2);
        src_sel = 2'h3;
        edges(1, 0);
        chk(count, 32'h3);
        @(negedge clk) {lv[0], tick_clr} = 2'b11;
        @(negedge clk) {lv[0], tick_clr} = 2'b00;
        chk({count[3:0], tick_irq}, 32'h9);
    endtask
    task automatic t_cal();
        src_sel = 2'h0;
        cal_en = 1'b1;
        edges(31, 0);
        chk(cal_out, 32'h0);
        edges(1, 0);
        chk(cal_out, 32'h1);
        edges(32, 0);
        chk(cal_out, 32'h0);
        cal_en = 1'b0;
    endtask
    // Address ten must be ignored on write and read as zero
    task automatic t_bkp();
        for (int i = 0; i < 11; i++) begin
            @(negedge clk) {bkp_wr, bkp_wr_addr, bkp_wr_data} = {1'b1, i[3:0], 16'hA000 | i[15:0]};
        end
        @(negedge clk) bkp_wr = 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk) bkp_rd_addr = i[3:0];
            @(negedge clk) chk(bkp_rd_data, i < 10 ? 32'hA000 | i : 32'h0);
        end
        @(negedge clk) srst = 1'b1;
        @(negedge clk) {srst, bkp_rd_addr} = {1'b0, 4'h3};
        @(negedge clk) chk(bkp_rd_data, 32'hA003);
        chk(count, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {srst, presc_wr, cnt_wr, cmp_wr, alarm_clr, tick_clr, cal_en, bkp_wr} = 8'h80;
        {src_sel, lv, presc_data, cnt_data, cmp_data} = '0;
        {bkp_wr_addr, bkp_rd_addr, bkp_wr_data} = '0;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_tick();
        t_alarm();
        t_load();
        t_src();
        t_cal();
        t_bkp();
        finish_test();
    end
    // About 500 cycles are needed; a hang is cut well beyond that
    initial begin
        #60000;
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
